//--- src/pulse_shape_regs.sv
// register bank for custom transmit pulse shape with its phase driver
// assumes a classic wishbone master on mclk and a mark strobe from the encoder
//
// What this block does
// RULE_01 - word one drives phase one code
// RULE_02 - word two drives phase two code
// RULE_03 - word three drives phase three code
// RULE_04 - word four drives phase four code
// RULE_05 - larger code gives larger amplitude
// RULE_06 - programmed words used only when select set
// RULE_07 - software keeps top bit at zero
// RULE_08 - select clear uses stored templates instead
// RULE_09 - words read back last written value
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/10ps
module pulse_shape_regs
  import pulse_shape_pkg::*;
#(
  // bus geometry; the register index sits above the byte offset
  parameter int ADDR_W = 10,
  parameter int DATA_W = 32,
  parameter int SEL_W = 4
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clk_en,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [SEL_W-1:0] wb_sel_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  output logic [DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // transmit side
  input wire logic [NUM_PHASES*MAG_W-1:0] template_codes,
  input wire logic mark_strobe,
  output logic [MAG_W-1:0] dac_code_q,
  output logic [PHASE_W-1:0] phase_q,
  output logic custom_shape_select
);

  // ==========================================================
  // geometry checks
  localparam int IDX_W = $bits(IDX_PHASE1);
  localparam int PAD_W = DATA_W - WORD_W;

  // the index must fill the address above the byte offset exactly
  if (ADDR_W != ADDR_SHIFT + IDX_W) begin : g_bad_addr
    $error("address width does not match the register index width");
  end
  // a register must fit in the data bus with room left above it
  if (DATA_W <= WORD_W) begin : g_bad_data
    $error("data width too narrow for a register word");
  end
  // one byte lane per select bit
  if (SEL_W * WORD_W != DATA_W) begin : g_bad_sel
    $error("select width does not match the data width");
  end

  // ==========================================================
  // state and decode signals
  shape_if shp ();
  logic [WORD_W-1:0] word_q [NUM_PHASES];
  logic [WORD_W-1:0] word_d [NUM_PHASES];
  logic [WORD_W-1:0] enable_q, enable_d;
  logic ack_q, ack_d, err_q, err_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic busy;
  logic req;
  logic [IDX_W-1:0] idx;
  int p;
  logic hit_word, hit_enable, hit_status, lane0_wr;

  // ==========================================================
  // decode helpers

  // index of a phase word, or NUM_PHASES when not a phase word
  function automatic int phase_of(input logic [IDX_W-1:0] i);
    if (i >= IDX_PHASE1 && i <= IDX_PHASE4) begin
      phase_of = int'(i - IDX_PHASE1);
    end else begin
      phase_of = NUM_PHASES;
    end
  endfunction

  // a write reaches a register only through the lowest byte lane
  function automatic logic lane0_write(input logic w, input logic [SEL_W-1:0] s);
    lane0_write = w && s[0];
  endfunction

  // status word: busy above the phase, select in bit zero, zero elsewhere
  function automatic logic [DATA_W-1:0] status_word(input logic b, input logic [PHASE_W-1:0] ph,
                                                    input logic s);
    status_word = '0;
    status_word[PHASE_W+1] = b;
    status_word[PHASE_W:1] = ph;
    status_word[0] = s;
  endfunction

  // ==========================================================
  // request decode; a pending answer masks the request so it is taken once
  assign req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
  assign idx = wb_adr_i[ADDR_SHIFT +: IDX_W];
  assign p = phase_of(idx);

  // address decode, one hit for the phase words and one each for enable and status
  assign hit_word = (p < NUM_PHASES);
  assign hit_enable = (idx == IDX_SHAPE_ENABLE);
  assign hit_status = (idx == IDX_TX_STATUS);
  assign lane0_wr = lane0_write(wb_we_i, wb_sel_i);

  // ==========================================================
  // bus answer: ack for a mapped index, err for any other

  // next answer; both stay low while no request is pending
  always_comb begin
    ack_d = 1'b0;
    err_d = 1'b0;
    if (req) begin
      if (hit_word || hit_enable || hit_status) begin
        ack_d = 1'b1;
      end else begin
        err_d = 1'b1;
      end
    end
  end

  // answer registers; a low clock enable also holds a pending answer
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end else if (clk_en) begin
      ack_q <= ack_d;
      err_q <= err_d;
    end
  end

  // ==========================================================
  // phase magnitude words

  // next words; the top bit is stored as written, software keeps it zero
  always_comb begin
    for (int k = 0; k < NUM_PHASES; k++) begin
      word_d[k] = word_q[k];
      if (req && hit_word && lane0_wr && p == k) begin
        word_d[k] = wb_dat_i[WORD_W-1:0]; // [RULE_09]
      end
    end
  end

  // word registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int k = 0; k < NUM_PHASES; k++) begin
        word_q[k] <= WORD_RESET;
      end
    end else if (clk_en) begin
      for (int k = 0; k < NUM_PHASES; k++) begin
        word_q[k] <= word_d[k];
      end
    end
  end

  // ==========================================================
  // shape enable register, only the select bit is used

  // next enable value
  always_comb begin
    enable_d = enable_q;
    if (req && hit_enable && lane0_wr) begin
      enable_d = wb_dat_i[WORD_W-1:0];
    end
  end

  // enable register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      enable_q <= ENABLE_RESET;
    end else if (clk_en) begin
      enable_q <= enable_d;
    end
  end

  // ==========================================================
  // read data; a read returns the value held before the access

  // next read data, held until the next access
  always_comb begin
    rdata_d = rdata_q;
    if (req) begin
      if (hit_word) begin
        for (int k = 0; k < NUM_PHASES; k++) begin
          if (p == k) begin
            rdata_d = {{PAD_W{1'b0}}, word_q[k]}; // [RULE_09]
          end
        end
      end else if (hit_enable) begin
        rdata_d = {{PAD_W{1'b0}}, enable_q};
      end else if (hit_status) begin
        rdata_d = status_word(busy, phase_q, shp.custom_shape_select);
      end else begin
        rdata_d = '0;
      end
    end
  end

  // read data register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= '0;
    end else if (clk_en) begin
      rdata_q <= rdata_d;
    end
  end

  // shape words to the driver, low seven bits only
  for (genvar g = 0; g < NUM_PHASES; g++) begin : g_mag
    assign shp.mag[g] = word_q[g][MAG_W-1:0];
  end
  assign shp.custom_shape_select = enable_q[SELECT_BIT]; // [RULE_06]

  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;
  assign wb_dat_o = rdata_q;
  assign custom_shape_select = enable_q[SELECT_BIT];

  // phase sequencer and code select
  pulse_phase_driver u_drv (
    .mclk(mclk),
    .resetn(resetn),
    .clk_en(clk_en),
    .shp(shp),
    .template_codes(template_codes),
    .mark_strobe(mark_strobe),
    .dac_code_q(dac_code_q),
    .phase_q(phase_q),
    .busy(busy)
  );

endmodule

//--- src/pulse_shape_pkg.sv
// package for the custom transmit pulse shape register bank
// assumes a 32-bit classic wishbone slave, one register per aligned word
package pulse_shape_pkg;

  // ==========================================================
  // register indices as printed, byte address is four times
  localparam logic [7:0] IDX_SHAPE_ENABLE = 8'h11;
  localparam logic [7:0] IDX_PHASE1 = 8'h1C;
  localparam logic [7:0] IDX_PHASE2 = 8'h1D;
  localparam logic [7:0] IDX_PHASE3 = 8'h1E;
  localparam logic [7:0] IDX_PHASE4 = 8'h1F;
  localparam logic [7:0] IDX_TX_STATUS = 8'h20;
  localparam int ADDR_SHIFT = 2;

  // ==========================================================
  // field layout
  localparam int MAG_W = 7;
  localparam int WORD_W = 8;
  localparam int SELECT_BIT = 3;
  localparam int NUM_PHASES = 4;
  localparam int PHASE_W = 2;

  // ==========================================================
  // reset values
  localparam logic [WORD_W-1:0] WORD_RESET = 8'h00;
  localparam logic [WORD_W-1:0] ENABLE_RESET = 8'h00;

  // ==========================================================
  // transmit phase sequencer states
  typedef enum logic [4:0] {
    PH_IDLE = 5'b00001,
    PH_ONE = 5'b00010,
    PH_TWO = 5'b00100,
    PH_THREE = 5'b01000,
    PH_FOUR = 5'b10000
  } phase_state_e;

endpackage

//--- src/shape_if.sv
// interface carrying the programmed shape words to the phase driver
// assumes both ends run on mclk
`timescale 1ns/10ps
interface shape_if;
  import pulse_shape_pkg::*;
  logic [MAG_W-1:0] mag [NUM_PHASES];
  logic custom_shape_select;
  modport regs (output mag, output custom_shape_select);
  modport drive (input mag, input custom_shape_select);
endinterface

//--- src/pulse_phase_driver.sv
// walks the four phases of a mark and picks each phase's converter code
// assumes mark_strobe and the template inputs are in the mclk domain
`timescale 1ns/10ps
module pulse_phase_driver
  import pulse_shape_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clk_en,
  // shape words
  shape_if.drive shp,
  // stored templates, one code per phase, chosen by build-out setting
  input wire logic [NUM_PHASES*MAG_W-1:0] template_codes,
  // mark timing
  input wire logic mark_strobe,
  // converter side
  output logic [MAG_W-1:0] dac_code_q,
  output logic [PHASE_W-1:0] phase_q,
  output logic busy
);

  phase_state_e state_q, state_d;
  logic [MAG_W-1:0] code_d;
  logic [PHASE_W-1:0] phase_d;

  // pick a phase's code: programmed word or template
  function automatic logic [MAG_W-1:0] pick(input logic [PHASE_W-1:0] p, input logic sel,
                                            input logic [MAG_W-1:0] m);
    logic [MAG_W-1:0] t;
    t = template_codes[p*MAG_W +: MAG_W];
    pick = sel ? m : t; // [RULE_06] [RULE_08]
  endfunction

  // ==========================================================
  // next state and code
  always_comb begin
    state_d = state_q;
    code_d = dac_code_q;
    phase_d = phase_q;
    case (state_q)
      PH_IDLE: begin
        code_d = '0;
        if (mark_strobe) begin
          state_d = PH_ONE;
          phase_d = 2'd0;
          code_d = pick(2'd0, shp.custom_shape_select, shp.mag[0]); // [RULE_01]
        end
      end
      PH_ONE: begin
        state_d = PH_TWO;
        phase_d = 2'd1;
        code_d = pick(2'd1, shp.custom_shape_select, shp.mag[1]); // [RULE_02]
      end
      PH_TWO: begin
        state_d = PH_THREE;
        phase_d = 2'd2;
        code_d = pick(2'd2, shp.custom_shape_select, shp.mag[2]); // [RULE_03]
      end
      PH_THREE: begin
        state_d = PH_FOUR;
        phase_d = 2'd3;
        code_d = pick(2'd3, shp.custom_shape_select, shp.mag[3]); // [RULE_04]
      end
      PH_FOUR: begin
        state_d = PH_IDLE;
        phase_d = 2'd0;
        code_d = '0;
      end
      default: begin
        state_d = PH_IDLE;
        code_d = '0;
      end
    endcase
  end

  // registers; the code passes unscaled so amplitude rises with value
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= PH_IDLE;
      dac_code_q <= '0;
      phase_q <= '0;
    end else if (clk_en) begin
      state_q <= state_d;
      dac_code_q <= code_d; // [RULE_05]
      phase_q <= phase_d;
    end
  end

  assign busy = (state_q != PH_IDLE);

endmodule

//--- testbench/pulse_shape_regs_asserts.sv
// checker for the pulse shape register bank
// assumes binding to pulse_shape_regs with clk_en held high
`timescale 1ns/10ps
module pulse_shape_regs_asserts
  import pulse_shape_pkg::*;
(
  // watched ports
  input wire logic mclk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic [NUM_PHASES*MAG_W-1:0] template_codes,
  input wire logic [MAG_W-1:0] dac_code_q,
  input wire logic [PHASE_W-1:0] phase_q,
  input wire logic custom_shape_select
);
  // ==========
  // request decode
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic req;
  logic [7:0] idx;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign idx = wb_adr_i[9:2];
  property p_ack; req |=> wb_ack_o != wb_err_o; endproperty
  a_ack: assert property (p_ack) else $error("request not answered once");
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack held too long");
  property p_err; req && idx == 8'h12 |=> wb_err_o; endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
  property p_hi; wb_ack_o |-> wb_dat_o[31:8] == 24'h000000; endproperty
  a_hi: assert property (p_hi) else $error("read data upper bits set");
  property p_sel;
    req && wb_we_i && wb_sel_i[0] && idx == IDX_SHAPE_ENABLE
      |=> custom_shape_select == $past(wb_dat_i[SELECT_BIT]);
  endproperty
  a_sel: assert property (p_sel) else $error("select bit not stored");
  property p_seq; phase_q inside {2'h1, 2'h2} |=> phase_q == $past(phase_q) + 2'h1; endproperty
  a_seq: assert property (p_seq) else $error("phase order broken");
  property p_end; phase_q == 2'h3 |=> phase_q == 2'h0 && dac_code_q == 7'h00; endproperty
  a_end: assert property (p_end) else $error("mark not closed");
  property p_tpl;
    phase_q != 2'h0 && !custom_shape_select && !$past(custom_shape_select)
      && !$past(custom_shape_select, 2) |-> dac_code_q == template_codes[phase_q*MAG_W +: MAG_W];
  endproperty
  a_tpl: assert property (p_tpl) else $error("template code not used");
endmodule
bind pulse_shape_regs pulse_shape_regs_asserts chk_i (.*);

//--- testbench/dac_model.sv
// converter model keeping the last code seen in each phase
// assumes codes within a mark are nonzero
`timescale 1ns/10ps
module dac_model
  import pulse_shape_pkg::*;
(
  // converter side
  input wire logic mclk,
  input wire logic [MAG_W-1:0] dac_code_q,
  input wire logic [PHASE_W-1:0] phase_q,
  // captured codes, phase p at [7p+6:7p]
  output logic [NUM_PHASES*MAG_W-1:0] seen
);
  // ==========
  // amplitude follows the code of each phase
  always @(posedge mclk) begin
    if (dac_code_q != 7'h00) begin
      seen[phase_q*MAG_W +: MAG_W] <= dac_code_q;
    end
  end
endmodule

//--- testbench/test_pulse_shape_regs.sv
// testbench for the pulse shape register bank
// assumes checker and converter model are compiled before it
`timescale 1ns/10ps
module test_pulse_shape_regs;
  import pulse_shape_pkg::*;
  logic mclk = 0, resetn = 0, cyc = 0, stb = 0, we = 0, mstb = 0, ack, err, sel_o, rerr;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, dout, rdat;
  logic [27:0] tpl = {7'h14, 7'h63, 7'h42, 7'h21}, seen;
  logic [6:0] dcode;
  logic [1:0] phs;
  int mismatches = 0, cmp_count = 0, cycles = 0;
  pulse_shape_regs uut (.mclk(mclk), .resetn(resetn), .clk_en(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dout), .wb_ack_o(ack), .wb_err_o(err), .template_codes(tpl),
    .mark_strobe(mstb), .dac_code_q(dcode), .phase_q(phs), .custom_shape_select(sel_o));
  dac_model u_dac (.mclk(mclk), .dac_code_q(dcode), .phase_q(phs), .seen(seen));
  // ==========
  // clock and hang guard
  initial forever #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      print_verdict();
    end
  end
  task print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one classic bus cycle, held until ack or err
  task wb(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s = 4'hF);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= s;
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    do begin
      @(posedge mclk);
    end while (ack !== 1'b1 && err !== 1'b1);
    rdat = dout;
    rerr = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task mark();
    @(posedge mclk);
    mstb <= 1'b1;
    @(posedge mclk);
    mstb <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask
  // ==========
  // scenarios
  task t_words();
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, IDX_PHASE1 + i, 8'h00);
      chk(rdat, 32'h0);
      wb(1'b1, IDX_PHASE1 + i, 8'h11 * (i + 1));
      wb(1'b0, IDX_PHASE1 + i, 8'h00);
      chk(rdat, 32'h11 * (i + 1));
    end
    // a write with the low byte lane off is acked but stores nothing
    wb(1'b1, IDX_PHASE2, 8'h5A, 4'h0);
    wb(1'b0, IDX_PHASE2, 8'h00);
    chk(rdat, 32'h00000022);
    wb(1'b1, 8'h12, 8'h55);
    chk(rerr, 1'b1);
    $display("words test done");
  endtask
  task t_template();
    mark();
    chk(seen, tpl);
    $display("template test done");
  endtask
  task t_custom();
    wb(1'b1, IDX_SHAPE_ENABLE, 8'h08);
    chk(sel_o, 1'b1);
    // status read taken while the first phase of the mark is out
    fork
      mark();
      begin
        @(posedge mclk);
        wb(1'b0, IDX_TX_STATUS, 8'h00);
      end
    join
    chk(rdat, 32'h00000009);
    chk(seen, {7'h44, 7'h33, 7'h22, 7'h11});
    wb(1'b1, IDX_PHASE1, 8'h7F);
    mark();
    chk(seen[6:0] > 7'h11, 1'b1);
    chk(seen[6:0], 7'h7F);
    wb(1'b1, IDX_SHAPE_ENABLE, 8'h00);
    $display("custom test done");
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    t_words();
    t_template();
    t_custom();
    t_template();
    print_verdict();
  end
endmodule
